// ---- logic/lcs_byte_reg.sv ----
`timescale 1ns/10ps
module lcs_byte_reg #(
   parameter int W = 8
) (
   input wire logic pclk, // Clock.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic wr_en, // Write strobe.
   input wire logic [W-1:0] wr_data, // Write data.
   output logic [W-1:0] value // Stored value.
);
   logic [W-1:0] value_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_q <= '0;
      end else if (wr_en) begin
         value_q <= wr_data;
      end
   end

   assign value = value_q;
endmodule

// ---- logic/lcs_code_join.sv ----
`timescale 1ns/10ps
module lcs_code_join (
   input wire logic [1:0] high_bits, // Code bits 9 and 8.
   input wire logic [7:0] low_byte, // Code bits 7 to 0.
   output logic [9:0] code // Joined 10-bit code.
);
   // The full range up to full scale passes unclamped.
   assign code = {high_bits, low_byte};
endmodule

// ---- logic/lcs_pkg.sv ----
package lcs_pkg;
   // -------------------------------------------------------------------
   // Register map (register indices; printed offsets are not word aligned,
   // so they are indices and the byte address is four times the index).
   // -------------------------------------------------------------------
   localparam logic [7:0] IDX_CHAN_A_HIGH = 8'h03;
   localparam logic [7:0] IDX_CHAN_A_LOW = 8'h04;
   localparam logic [7:0] IDX_CHAN_B_HIGH = 8'h05;
   localparam logic [7:0] IDX_CHAN_B_LOW = 8'h06;
   localparam logic [7:0] IDX_CHAN_C_HIGH = 8'h07;
   localparam logic [7:0] IDX_CHAN_C_LOW = 8'h08;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int CODE_W = 10;
   localparam int HIGH_W = 2;
   localparam logic [9:0] CODE_FULL_SCALE = 10'h3ff;
   // Typical current per code step in microamps, and full scale in mA.
   localparam int STEP_UA = 2470;
   localparam int FULL_SCALE_MA = 2528;

   typedef struct packed {
      logic [9:0] chan_a_current_code;
      logic [9:0] chan_b_current_code;
      logic [9:0] chan_c_current_code;
   } lcs_codes_t;

   function automatic logic [11:0] idx_to_addr(input logic [7:0] idx);
      idx_to_addr = {2'h0, idx, 2'h0};
   endfunction
endpackage

// ---- logic/lcs_regs.sv ----
`timescale 1ns/10ps
module lcs_regs (
   input wire logic pclk, // APB clock, 50 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   input wire logic [3:0] pstrb, // APB byte strobes.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error on unmapped address.
   output lcs_pkg::lcs_codes_t codes // Codes to the current regulator.
);
   // -------------------------------------------------------------------
   // Address decode
   // -------------------------------------------------------------------
   wire logic access = psel && penable;
   wire logic wr = access && pwrite && pstrb[0];
   wire logic sel_a_hi =
      paddr == lcs_pkg::idx_to_addr(lcs_pkg::IDX_CHAN_A_HIGH);
   wire logic sel_a_lo =
      paddr == lcs_pkg::idx_to_addr(lcs_pkg::IDX_CHAN_A_LOW);
   wire logic sel_b_hi =
      paddr == lcs_pkg::idx_to_addr(lcs_pkg::IDX_CHAN_B_HIGH);
   wire logic sel_b_lo =
      paddr == lcs_pkg::idx_to_addr(lcs_pkg::IDX_CHAN_B_LOW);
   wire logic sel_c_hi =
      paddr == lcs_pkg::idx_to_addr(lcs_pkg::IDX_CHAN_C_HIGH);
   wire logic sel_c_lo =
      paddr == lcs_pkg::idx_to_addr(lcs_pkg::IDX_CHAN_C_LOW);
   wire logic mapped = sel_a_hi | sel_a_lo | sel_b_hi | sel_b_lo |
      sel_c_hi | sel_c_lo;

   // -------------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------------
   logic [7:0] a_hi, a_lo, b_hi, b_lo, c_hi, c_lo;

   lcs_byte_reg u_a_hi (.pclk(pclk), .presetn(presetn),
      .wr_en(wr && sel_a_hi), .wr_data(pwdata[7:0]), .value(a_hi));
   lcs_byte_reg u_a_lo (.pclk(pclk), .presetn(presetn),
      .wr_en(wr && sel_a_lo), .wr_data(pwdata[7:0]), .value(a_lo));
   lcs_byte_reg u_b_hi (.pclk(pclk), .presetn(presetn),
      .wr_en(wr && sel_b_hi), .wr_data(pwdata[7:0]), .value(b_hi));
   lcs_byte_reg u_b_lo (.pclk(pclk), .presetn(presetn),
      .wr_en(wr && sel_b_lo), .wr_data(pwdata[7:0]), .value(b_lo));
   lcs_byte_reg u_c_hi (.pclk(pclk), .presetn(presetn),
      .wr_en(wr && sel_c_hi), .wr_data(pwdata[7:0]), .value(c_hi));
   lcs_byte_reg u_c_lo (.pclk(pclk), .presetn(presetn),
      .wr_en(wr && sel_c_lo), .wr_data(pwdata[7:0]), .value(c_lo));

   // -------------------------------------------------------------------
   // Code joining
   // -------------------------------------------------------------------
   logic [9:0] code_a, code_b, code_c;

   lcs_code_join u_join_a (.high_bits(a_hi[1:0]), .low_byte(a_lo),
      .code(code_a));
   lcs_code_join u_join_b (.high_bits(b_hi[1:0]), .low_byte(b_lo),
      .code(code_b));
   lcs_code_join u_join_c (.high_bits(c_hi[1:0]), .low_byte(c_lo),
      .code(code_c));

   // -------------------------------------------------------------------
   // Read mux
   // -------------------------------------------------------------------
   // The undefined upper bits of the high registers read back as written.
   wire logic [7:0] rd_byte = ({8{sel_a_hi}} & a_hi) |
      ({8{sel_a_lo}} & a_lo) |
      ({8{sel_b_hi}} & b_hi) | ({8{sel_b_lo}} & b_lo) |
      ({8{sel_c_hi}} & c_hi) | ({8{sel_c_lo}} & c_lo);

   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   logic pready_q;
   lcs_pkg::lcs_codes_t codes_q, codes_d;

   assign prdata_d = (psel && !penable && !pwrite) ? {24'h000000, rd_byte}
      : prdata_q;
   assign pslverr_d = psel && !penable && !mapped;
   // The regulator sees a new code one cycle after the write edge.
   assign codes_d = '{chan_a_current_code: code_a,
      chan_b_current_code: code_b, chan_c_current_code: code_c};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
         pready_q <= 1'b1;
         codes_q <= '0;
      end else begin
         pready_q <= 1'b1;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
         codes_q <= codes_d;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   // Zero wait states: every access phase completes in one cycle.
   assign pready = pready_q;
   assign codes = codes_q;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   sequence s_write_a_lo;
      wr && sel_a_lo;
   endsequence

   a_write_a_low: assert property (@(posedge pclk) disable iff (!presetn)
      s_write_a_lo |-> ##2 codes.chan_a_current_code[7:0] ==
      $past(pwdata[7:0], 2)) else $error("channel a low byte lost");
   a_write_b_high: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_b_hi |-> ##2 codes.chan_b_current_code[9:8] ==
      $past(pwdata[1:0], 2)) else $error("channel b high bits lost");
   a_write_b_low: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_b_lo |-> ##2 codes.chan_b_current_code[7:0] ==
      $past(pwdata[7:0], 2)) else $error("channel b low byte lost");
   a_write_c_high: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_c_hi |-> ##2 codes.chan_c_current_code[9:8] ==
      $past(pwdata[1:0], 2)) else $error("channel c high bits lost");
   a_full_scale_kept: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_a_lo && pwdata[7:0] == 8'hff ##1 a_hi[1:0] == 2'h3 |->
      ##1 codes.chan_a_current_code == lcs_pkg::CODE_FULL_SCALE)
      else $error("full scale code clamped");
   a_code_stable: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && mapped) |-> ##2 $stable(codes))
      else $error("code changed without a write");
   a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> pslverr && pready)
      else $error("unmapped access not flagged");
   a_mapped_no_error: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && mapped |=> !pslverr)
      else $error("mapped access flagged");
   a_read_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite |=> prdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_write_a_high: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_a_hi |-> ##2 codes.chan_a_current_code[9:8] ==
      $past(pwdata[1:0], 2)) else $error("channel a high bits lost");
   a_write_c_low: assert property (@(posedge pclk) disable iff (!presetn)
      wr && sel_c_lo |-> ##2 codes.chan_c_current_code[7:0] ==
      $past(pwdata[7:0], 2)) else $error("channel c low byte lost");
   a_readback: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && sel_b_lo |=> prdata[7:0] ==
      codes.chan_b_current_code[7:0]) else $error("readback wrong");
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   lcs_pkg::lcs_codes_t codes;
   logic [32:0] exp_q[$];
   logic [7:0] shadow [3:8];
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   lcs_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .codes(codes));
   initial begin
      forever #10 pclk = ~pclk;
   end
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      cmp_count++;
      if (seen !== want) begin
         failures++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic final_report();
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ------------------------------------------------------------------
   // APB master; one idle cycle separates transfers.
   // ------------------------------------------------------------------
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [7:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input int i, input logic [32:0] want);
      exp_q.push_back(want);
      apb(1'b0, 12'(i * 4), 8'h00, 4'hf);
   endtask
   task automatic rd_all();
      for (int i = 3; i <= 8; i++) begin
         rd(i, {25'h0, shadow[i]});
      end
   endtask
   task automatic wr(input int i, input logic [7:0] v, input logic [3:0] s);
      apb(1'b1, 12'(i * 4), v, s);
      repeat (3) @(posedge pclk);
      #1;
      check({3'h0, codes}, {3'h0, shadow[3][1:0], shadow[4], shadow[5][1:0],
         shadow[6], shadow[7][1:0], shadow[8]});
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         final_report();
      end
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            failures++;
         end else begin
            check({pslverr, prdata}, exp_q.pop_front());
         end
      end
   end
   initial begin
      logic [7:0] v;
      void'($urandom(18972));
      foreach (shadow[i]) shadow[i] = 8'h00;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_all();
      for (int r = 0; r < 8; r++) begin
         for (int i = 3; i <= 8; i++) begin
            v = (r == 0) ? 8'hff : 8'($urandom);
            shadow[i] = v;
            wr(i, v, 4'hf);
         end
         rd_all();
      end
      wr(4, ~shadow[4], 4'he);
      rd(9, {1'b1, 32'h0});
      apb(1'b1, 12'h000, 8'h5a, 4'hf);
      rd_all();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (shadow[i]) shadow[i] = 8'h00;
      wr(8, 8'h00, 4'hf);
      rd_all();
      repeat (3) @(posedge pclk);
      check(33'(exp_q.size()), 33'h0);
      final_report();
   end
endmodule
